// File: gef_engine.sv
`timescale 1ns/10ps
module gef_engine #(
   // Serial bus address, value arbitrary
   parameter logic [6:0]  I2C_ADDR       = 7'h2a,
   parameter logic [15:0] PULSE_UNIT_CYC = 16'h0004,
   parameter logic [15:0] WAIT_STEP_CYC  = 16'h0010
) (
   // Clocks, reset, enable
   input  wire logic        i_sys_clk,
   input  wire logic        i_osc_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_clk_en,
   // Serial bus pins
   input  wire logic        i_scl,
   input  wire logic        i_sda_in,
   output logic             o_sda_out,
   output logic             o_sda_oe,
   // Proximity results, system clock
   input  wire logic        i_prox_valid,
   input  wire logic [7:0]  i_prox_result,
   // Photodiode converter, oscillator clock
   input  wire logic [31:0] i_pd_sample,
   // LED and front end
   output logic             o_led_on,
   output logic [1:0]       o_led_drive,
   output logic [1:0]       o_led_boost,
   output logic [1:0]       o_amp_gain,
   output logic             o_engine_active,
   // Interrupt pin
   output logic             o_int_n
);
   logic [7:0]  enable_r, config_one_low_power_r, config_two_led_boost_r, entry_th_r, exit_th_r;
   logic [7:0]  gconf1_r, gconf2_r, pulse_r, gconf3_r;
   logic [7:0]  off_r [4];
   logic        gien_r, gmode_r, gvalid_r, motion_interrupt_flag_r, gfov_r, seen_valid_r, run_d_r;
   logic [1:0]  pers_cnt_r;
   logic [31:0] mem_r [gef_pkg::FIFO_DEPTH];
   logic [4:0]  wr_ptr_r, rd_ptr_r;
   logic [5:0]  level_r, level_nxt, thr_lvl;
   // Serial bus slave state
   logic [2:0]  scl_q, sda_q;
   gef_pkg::gef_sb_state_t sb_st_r;
   logic [2:0]  bit_r;
   logic [7:0]  sh_r, ptr_r, rd_mux;
   logic        ack_pend_r, ack_on_r, load_pend_r, sda_oe_r;
   logic        wr_stb_r, pop_stb_r;
   logic [7:0]  wr_adr_r, wr_dat_r;
   // Engine domain and crossing
   logic [13:0] cfg_s1, cfg_s2;
   logic [1:0]  ack_sq;
   logic [1:0]  req_sq;
   logic        req_r, ack_r, led_r;
   logic [31:0] acc_r, acc_nxt, eng_data_r, proc;
   logic [15:0] tcnt_r;
   logic [5:0]  pcnt_r;
   gef_pkg::gef_eng_state_t est_r;

   wire [7:0] pbyte = {sh_r[6:0], sda_q[1]};
   wire scl_rise = scl_q[1] & ~scl_q[2];
   wire scl_fall = ~scl_q[1] & scl_q[2];
   wire sb_start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   wire sb_stop  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
   wire [7:0] ptr_inc = (ptr_r == gef_pkg::ADDR_FIFO_RGT) ? gef_pkg::ADDR_FIFO_UP
                        : ptr_r + 8'h01;

   assign o_sda_out = 1'b0;
   assign o_sda_oe  = sda_oe_r;

   // Slow serial clock is oversampled; SDA changes only after SCL falls
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else if (i_clk_en) begin
         scl_q <= {scl_q[1:0], i_scl};
         sda_q <= {sda_q[1:0], i_sda_in};
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sb_st_r <= gef_pkg::SB_IDLE;
         bit_r <= 3'h0;
         sh_r <= 8'h00;
         ptr_r <= 8'h00;
         ack_pend_r <= 1'b0;
         ack_on_r <= 1'b0;
         load_pend_r <= 1'b0;
         sda_oe_r <= 1'b0;
         wr_stb_r <= 1'b0;
         pop_stb_r <= 1'b0;
         wr_adr_r <= 8'h00;
         wr_dat_r <= 8'h00;
      end else if (i_clk_en) begin
         wr_stb_r <= 1'b0;
         pop_stb_r <= 1'b0;
         if (sb_start || sb_stop) begin
            sb_st_r <= sb_start ? gef_pkg::SB_ADDR : gef_pkg::SB_IDLE;
            bit_r <= 3'h0;
            ack_pend_r <= 1'b0;
            ack_on_r <= 1'b0;
            load_pend_r <= 1'b0;
            sda_oe_r <= 1'b0;
         end else if (scl_rise && !ack_on_r) begin
            bit_r <= bit_r + 3'h1;
            sh_r <= pbyte;
            case (sb_st_r)
               gef_pkg::SB_ADDR: if (bit_r == 3'h7) begin
                  ack_pend_r <= (pbyte[7:1] == I2C_ADDR);
                  load_pend_r <= (pbyte[7:1] == I2C_ADDR) && pbyte[0];
                  sb_st_r <= (pbyte[7:1] != I2C_ADDR) ? gef_pkg::SB_IDLE
                             : pbyte[0] ? gef_pkg::SB_RDAT : gef_pkg::SB_REG;
               end
               gef_pkg::SB_REG: if (bit_r == 3'h7) begin
                  ptr_r <= pbyte;
                  ack_pend_r <= 1'b1;
                  sb_st_r <= gef_pkg::SB_WDAT;
               end
               gef_pkg::SB_WDAT: if (bit_r == 3'h7) begin
                  wr_stb_r <= 1'b1;
                  wr_adr_r <= ptr_r;
                  wr_dat_r <= pbyte;
                  ptr_r <= ptr_inc;
                  ack_pend_r <= 1'b1;
               end
               gef_pkg::SB_RDAT: if (bit_r == 3'h7) sb_st_r <= gef_pkg::SB_RACK;
               gef_pkg::SB_RACK: begin
                  load_pend_r <= ~sda_q[1];
                  sb_st_r <= sda_q[1] ? gef_pkg::SB_IDLE : gef_pkg::SB_RDAT;
               end
               default: sb_st_r <= gef_pkg::SB_IDLE;
            endcase
         end else if (scl_fall) begin
            if (ack_pend_r) begin
               ack_pend_r <= 1'b0;
               ack_on_r <= 1'b1;
               sda_oe_r <= 1'b1;
            end else if (load_pend_r) begin
               // Pointer walks U, D, L, R and wraps inside the FIFO window
               load_pend_r <= 1'b0;
               ack_on_r <= 1'b0;
               sh_r <= rd_mux;
               sda_oe_r <= ~rd_mux[7];
               bit_r <= 3'h0;
               ptr_r <= ptr_inc;
               pop_stb_r <= (ptr_r == gef_pkg::ADDR_FIFO_RGT);
            end else if (ack_on_r) begin
               ack_on_r <= 1'b0;
               sda_oe_r <= 1'b0;
               bit_r <= 3'h0;
            end else if (sb_st_r == gef_pkg::SB_RDAT) begin
               // The rising edge already shifted, so the next bit sits at the top
               sda_oe_r <= ~sh_r[7];
            end else begin
               sda_oe_r <= 1'b0;
            end
         end
      end
   end

   // Register read decode
   wire         fifo_empty = (level_r == 6'h00);
   wire [31:0]  head = fifo_empty ? 32'h0 : mem_r[rd_ptr_r];
   always_comb begin
      case (ptr_r)
         gef_pkg::ADDR_ENABLE:    rd_mux = enable_r;
         gef_pkg::ADDR_CONFIG_ONE_LOW_POWER:   rd_mux = config_one_low_power_r;
         gef_pkg::ADDR_CONFIG_TWO_LED_BOOST:   rd_mux = config_two_led_boost_r;
         gef_pkg::ADDR_ENTRY_TH:  rd_mux = entry_th_r;
         gef_pkg::ADDR_EXIT_TH:   rd_mux = exit_th_r;
         gef_pkg::ADDR_GCONF1:    rd_mux = gconf1_r;
         gef_pkg::ADDR_GCONF2:    rd_mux = gconf2_r;
         gef_pkg::ADDR_OFF_UP:    rd_mux = off_r[0];
         gef_pkg::ADDR_OFF_DOWN:  rd_mux = off_r[1];
         gef_pkg::ADDR_PULSE:     rd_mux = pulse_r;
         gef_pkg::ADDR_OFF_LEFT:  rd_mux = off_r[2];
         gef_pkg::ADDR_OFF_RIGHT: rd_mux = off_r[3];
         gef_pkg::ADDR_GCONF3:    rd_mux = gconf3_r;
         gef_pkg::ADDR_GCONF4:    rd_mux = {6'h00, gien_r, gmode_r};
         gef_pkg::ADDR_LEVEL:     rd_mux = {2'h0, level_r};
         gef_pkg::ADDR_GESTURE_STATUS_FLAGS:   rd_mux = {6'h00, gfov_r, gvalid_r};
         gef_pkg::ADDR_FIFO_UP:   rd_mux = head[7:0];
         gef_pkg::ADDR_FIFO_DOWN: rd_mux = head[15:8];
         gef_pkg::ADDR_FIFO_LEFT: rd_mux = head[23:16];
         gef_pkg::ADDR_FIFO_RGT:  rd_mux = head[31:24];
         default:                 rd_mux = 8'h00;
      endcase
   end

   // Control register writes
   wire wr_g4 = wr_stb_r && (wr_adr_r == gef_pkg::ADDR_GCONF4);
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         enable_r <= gef_pkg::RST_ZERO;
         config_one_low_power_r <= gef_pkg::RST_CONFIG_ONE_LOW_POWER;
         config_two_led_boost_r <= gef_pkg::RST_CONFIG_TWO_LED_BOOST;
         entry_th_r <= gef_pkg::RST_ZERO;
         exit_th_r <= gef_pkg::RST_ZERO;
         gconf1_r <= gef_pkg::RST_ZERO;
         gconf2_r <= gef_pkg::RST_ZERO;
         pulse_r <= gef_pkg::RST_PULSE;
         gconf3_r <= gef_pkg::RST_ZERO;
         gien_r <= 1'b0;
         off_r <= '{default: gef_pkg::RST_ZERO};
      end else if (i_clk_en && wr_stb_r) begin
         case (wr_adr_r)
            gef_pkg::ADDR_ENABLE:    enable_r <= wr_dat_r;
            gef_pkg::ADDR_CONFIG_ONE_LOW_POWER:   config_one_low_power_r <= wr_dat_r;
            gef_pkg::ADDR_CONFIG_TWO_LED_BOOST:   config_two_led_boost_r <= wr_dat_r;
            gef_pkg::ADDR_ENTRY_TH:  entry_th_r <= wr_dat_r;
            gef_pkg::ADDR_EXIT_TH:   exit_th_r <= wr_dat_r;
            gef_pkg::ADDR_GCONF1:    gconf1_r <= wr_dat_r;
            gef_pkg::ADDR_GCONF2:    gconf2_r <= wr_dat_r;
            gef_pkg::ADDR_OFF_UP:    off_r[0] <= wr_dat_r;
            gef_pkg::ADDR_OFF_DOWN:  off_r[1] <= wr_dat_r;
            gef_pkg::ADDR_PULSE:     pulse_r <= wr_dat_r;
            gef_pkg::ADDR_OFF_LEFT:  off_r[2] <= wr_dat_r;
            gef_pkg::ADDR_OFF_RIGHT: off_r[3] <= wr_dat_r;
            gef_pkg::ADDR_GCONF3:    gconf3_r <= wr_dat_r;
            gef_pkg::ADDR_GCONF4:    gien_r <= wr_dat_r[gef_pkg::G4_IEN];
            default: ;
         endcase
      end
   end

   assign o_led_drive = gconf2_r[gef_pkg::G2_DRIVE_LSB +: 2];
   assign o_led_boost = config_two_led_boost_r[gef_pkg::C2_BOOST_LSB +: 2];
   assign o_amp_gain  = gconf2_r[gef_pkg::G2_GAIN_LSB +: 2];

   // Dataset handshake from the oscillator domain
   wire run       = enable_r[gef_pkg::EN_PON] & enable_r[gef_pkg::EN_GEN] & gmode_r;
   wire ud_only   = (gconf3_r[gef_pkg::G3_DIMS_LSB +: 2] == gef_pkg::DIMS_UD_ONLY);
   wire ds_new    = (req_sq[1] != ack_r) & run;
   wire fifo_full = (level_r == gef_pkg::FIFO_FULL_LVL);
   wire push      = ds_new & ~fifo_full;
   wire pop       = pop_stb_r & ~fifo_empty;
   wire [3:0] below;
   for (genvar d = 0; d < 4; d++) begin : g_dir
      logic [10:0] wide;
      logic [7:0]  gained;
      assign wide   = {3'h0, eng_data_r[8*d +: 8]} << o_amp_gain;
      assign gained = (|wide[10:8]) ? 8'hff : wide[7:0];
      // Offset floors at zero rather than wrapping
      assign proc[8*d +: 8] = (ud_only && d >= 2) ? 8'h00 :
                              (gained > off_r[d]) ? gained - off_r[d] : 8'h00;
      assign below[d] = gconf1_r[gef_pkg::G1_MASK_LSB + 3 - d] |
                        (proc[8*d +: 8] < exit_th_r);
   end

   wire       all_below = &below;
   wire [2:0] pers_inc  = {1'b0, pers_cnt_r} + 3'h1;
   wire       exit_hit  = ds_new & all_below &
                          (pers_inc >= {1'b0, gconf1_r[gef_pkg::G1_PERS_LSB +: 2]});
   wire       prox_set  = i_prox_valid & enable_r[gef_pkg::EN_PON] &
                          enable_r[gef_pkg::EN_GEN] & (i_prox_result >= entry_th_r);
   wire       exit_evt  = run_d_r & ~run;
   wire       purge     = (wr_g4 & wr_dat_r[gef_pkg::G4_CLR]) |
                          (exit_evt & ~seen_valid_r);
   wire [1:0] fifo_th   = gconf1_r[gef_pkg::G1_FIFOTH_LSB +: 2];
   assign thr_lvl   = (fifo_th == 2'h0) ? 6'h01 : {1'b0, fifo_th, 3'h0};
   assign level_nxt = purge ? 6'h00 : level_r + {5'h0, push} - {5'h0, pop};
   wire       at_thr    = (level_nxt != 6'h00) && (level_nxt >= thr_lvl);

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         gmode_r <= 1'b0;
         pers_cnt_r <= 2'h0;
         run_d_r <= 1'b0;
         ack_r <= 1'b0;
         req_sq[1:0] <= 2'h0;
      end else if (i_clk_en) begin
         req_sq[1:0] <= {req_sq[0], req_r};
         ack_r <= req_sq[1];
         run_d_r <= run;
         // Proximity entry outranks exit and host clear in the same cycle
         if (prox_set)
            gmode_r <= 1'b1;
         else if (exit_hit)
            gmode_r <= 1'b0;
         else if (wr_g4)
            gmode_r <= wr_dat_r[gef_pkg::G4_MODE];
         if (ds_new)
            pers_cnt_r <= (all_below && !exit_hit) ? pers_inc[1:0] : 2'h0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_ptr_r <= 5'h00;
         rd_ptr_r <= 5'h00;
         level_r <= 6'h00;
         gvalid_r <= 1'b0;
         motion_interrupt_flag_r <= 1'b0;
         gfov_r <= 1'b0;
         seen_valid_r <= 1'b0;
      end else if (i_clk_en) begin
         level_r <= level_nxt;
         wr_ptr_r <= purge ? 5'h00 : wr_ptr_r + {4'h0, push};
         rd_ptr_r <= purge ? 5'h00 : rd_ptr_r + {4'h0, pop};
         gvalid_r <= (level_nxt == 6'h00) ? 1'b0 : (at_thr | gvalid_r);
         motion_interrupt_flag_r <= (level_nxt == 6'h00) ? 1'b0 :
                   (at_thr | motion_interrupt_flag_r | (exit_evt & gvalid_r));
         if (purge)
            gfov_r <= 1'b0;
         else if (ds_new && fifo_full)
            gfov_r <= 1'b1;
         seen_valid_r <= (run & ~run_d_r) ? 1'b0 : (seen_valid_r | gvalid_r);
      end
   end

   // Storage is written only, never reset
   always_ff @(posedge i_sys_clk) begin
      if (i_clk_en && push)
         mem_r[wr_ptr_r] <= proc;
   end

   assign o_int_n = ~(motion_interrupt_flag_r & gien_r);
   assign o_engine_active = run;

   // Oscillator domain: config is quasi-static, run and enable are levels
   wire [13:0] cfg_src = {i_clk_en, run, ud_only, pulse_r, gconf2_r[gef_pkg::G2_WAIT_LSB +: 3]};
   wire        e_en    = cfg_s2[13];
   wire        e_run   = cfg_s2[12];
   wire        e_ud    = cfg_s2[11];
   wire [1:0]  e_plen  = cfg_s2[10:9];
   wire [5:0]  e_pcnt  = cfg_s2[8:3];
   wire [2:0]  e_wait  = cfg_s2[2:0];
   wire [15:0] pl_full = PULSE_UNIT_CYC << e_plen;
   wire [15:0] pl_cyc  = e_ud ? {1'b0, pl_full[15:1]} : pl_full;
   wire [15:0] wt_cyc  = 16'(WAIT_STEP_CYC * e_wait);
   wire        pl_end  = (tcnt_r == pl_cyc - 16'h0001);

   for (genvar d = 0; d < 4; d++) begin : g_acc
      logic [8:0] s;
      assign s = {1'b0, acc_r[8*d +: 8]} +
                 {1'b0, (e_ud && d >= 2) ? 8'h00 : i_pd_sample[8*d +: 8]};
      assign acc_nxt[8*d +: 8] = s[8] ? 8'hff : s[7:0];
   end

   always_ff @(posedge i_osc_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cfg_s1 <= 14'h0;
         cfg_s2 <= 14'h0;
         ack_sq <= 2'h0;
      end else begin
         cfg_s1 <= cfg_src;
         cfg_s2 <= cfg_s1;
         ack_sq <= {ack_sq[0], ack_r};
      end
   end

   always_ff @(posedge i_osc_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         est_r <= gef_pkg::EG_IDLE;
         tcnt_r <= 16'h0;
         pcnt_r <= 6'h0;
         acc_r <= 32'h0;
         eng_data_r <= 32'h0;
         req_r <= 1'b0;
         led_r <= 1'b0;
      end else if (e_en) begin
         case (est_r)
            gef_pkg::EG_IDLE: if (e_run) begin
               est_r <= gef_pkg::EG_PULSE;
               tcnt_r <= 16'h0;
               pcnt_r <= 6'h0;
               acc_r <= 32'h0;
               led_r <= 1'b1;
            end
            gef_pkg::EG_PULSE: if (!e_run) begin
               est_r <= gef_pkg::EG_IDLE;
               led_r <= 1'b0;
            end else if (pl_end) begin
               acc_r <= acc_nxt;
               tcnt_r <= 16'h0;
               pcnt_r <= pcnt_r + 6'h01;
               if (pcnt_r == e_pcnt) begin
                  eng_data_r <= acc_nxt;
                  req_r <= ~req_r;
                  led_r <= 1'b0;
                  est_r <= gef_pkg::EG_SEND;
               end
            end else begin
               tcnt_r <= tcnt_r + 16'h0001;
            end
            gef_pkg::EG_SEND: if (ack_sq[1] == req_r) begin
               tcnt_r <= 16'h0;
               est_r <= (e_wait != 3'h0) ? gef_pkg::EG_WAIT : gef_pkg::EG_IDLE;
            end
            gef_pkg::EG_WAIT: if (tcnt_r >= wt_cyc - 16'h0001)
               est_r <= gef_pkg::EG_IDLE;
            else
               tcnt_r <= tcnt_r + 16'h0001;
            default: est_r <= gef_pkg::EG_IDLE;
         endcase
      end
   end

   assign o_led_on = led_r;

   chk_run_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      o_engine_active |-> gmode_r && enable_r[gef_pkg::EN_GEN] && enable_r[gef_pkg::EN_PON])
      else $error("engine active without enable and mode");
   chk_entry_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_clk_en && prox_set |=> gmode_r) else $error("proximity entry did not set mode");
   chk_exit_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_clk_en && exit_hit && !prox_set |=> !gmode_r ##1 !o_engine_active)
      else $error("exit condition did not clear mode");
   chk_pers_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_clk_en && ds_new && !all_below |=> pers_cnt_r == 2'h0)
      else $error("persistence count not reset");
   chk_fifo_ovfl: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_clk_en && ds_new && fifo_full && !purge && !pop |=> gfov_r &&
      level_r == gef_pkg::FIFO_FULL_LVL)
      else $error("overflow not flagged or level changed");
   chk_valid_set: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_clk_en && at_thr |=> gvalid_r && motion_interrupt_flag_r && (!gien_r || !o_int_n))
      else $error("threshold did not raise valid and interrupt");
   chk_final_int: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_clk_en && exit_evt && gvalid_r && !purge && !pop |=> motion_interrupt_flag_r)
      else $error("no final interrupt at exit");
   chk_false_purge: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_clk_en && exit_evt && !seen_valid_r |=> level_r == 6'h00 && !motion_interrupt_flag_r)
      else $error("false gesture not purged");
   chk_empty_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_clk_en && pop && level_r == 6'h01 && !push |=> !gvalid_r && !motion_interrupt_flag_r && fifo_empty)
      else $error("emptying did not clear flags");
   chk_pop_step: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
      i_clk_en && pop && !push && !purge |=> level_r == $past(level_r) - 6'h01)
      else $error("pop did not lower level by one");
endmodule

// File: gef_pkg.sv
package gef_pkg;
   // Register byte addresses on the serial bus
   localparam logic [7:0] ADDR_ENABLE    = 8'h80;
   localparam logic [7:0] ADDR_CONFIG_ONE_LOW_POWER   = 8'h8d;
   localparam logic [7:0] ADDR_CONFIG_TWO_LED_BOOST   = 8'h90;
   localparam logic [7:0] ADDR_STATUS    = 8'h93;
   localparam logic [7:0] ADDR_ENTRY_TH  = 8'ha0;
   localparam logic [7:0] ADDR_EXIT_TH   = 8'ha1;
   localparam logic [7:0] ADDR_GCONF1    = 8'ha2;
   localparam logic [7:0] ADDR_GCONF2    = 8'ha3;
   localparam logic [7:0] ADDR_OFF_UP    = 8'ha4;
   localparam logic [7:0] ADDR_OFF_DOWN  = 8'ha5;
   localparam logic [7:0] ADDR_PULSE     = 8'ha6;
   localparam logic [7:0] ADDR_OFF_LEFT  = 8'ha7;
   localparam logic [7:0] ADDR_OFF_RIGHT = 8'ha9;
   localparam logic [7:0] ADDR_GCONF3    = 8'haa;
   localparam logic [7:0] ADDR_GCONF4    = 8'hab;
   localparam logic [7:0] ADDR_LEVEL     = 8'hae;
   localparam logic [7:0] ADDR_GESTURE_STATUS_FLAGS   = 8'haf;
   localparam logic [7:0] ADDR_FIFO_UP   = 8'hfc;
   localparam logic [7:0] ADDR_FIFO_DOWN = 8'hfd;
   localparam logic [7:0] ADDR_FIFO_LEFT = 8'hfe;
   localparam logic [7:0] ADDR_FIFO_RGT  = 8'hff;
   // Reset values
   localparam logic [7:0] RST_ZERO    = 8'h00;
   localparam logic [7:0] RST_CONFIG_ONE_LOW_POWER = 8'h60;
   localparam logic [7:0] RST_CONFIG_TWO_LED_BOOST = 8'h01;
   localparam logic [7:0] RST_PULSE   = 8'h40;
   // Bit and field positions
   localparam int EN_PON = 0;
   localparam int EN_GEN = 6;
   localparam int G4_MODE = 0;
   localparam int G4_IEN = 1;
   localparam int G4_CLR = 2;
   localparam int GS_VALID = 0;
   localparam int GS_OVFL = 1;
   localparam int G1_FIFOTH_LSB = 6;
   localparam int G1_MASK_LSB = 2;
   localparam int G1_PERS_LSB = 0;
   localparam int G2_GAIN_LSB = 5;
   localparam int G2_DRIVE_LSB = 3;
   localparam int G2_WAIT_LSB = 0;
   localparam int C2_BOOST_LSB = 4;
   localparam int PU_LEN_LSB = 6;
   localparam int PU_CNT_LSB = 0;
   localparam int G3_DIMS_LSB = 0;
   localparam logic [1:0] DIMS_UD_ONLY = 2'h1;
   // FIFO geometry
   localparam int FIFO_DEPTH = 32;
   localparam logic [5:0] FIFO_FULL_LVL = 6'h20;
   // Serial bus and engine state machines
   typedef enum logic [2:0] {
      SB_IDLE = 3'h0, SB_ADDR = 3'h1, SB_REG = 3'h2, SB_WDAT = 3'h3,
      SB_RDAT = 3'h4, SB_RACK = 3'h5
   } gef_sb_state_t;
   typedef enum logic [1:0] {
      EG_IDLE = 2'h0, EG_PULSE = 2'h1, EG_SEND = 2'h2, EG_WAIT = 2'h3
   } gef_eng_state_t;
endpackage

// File: gef_host.sv
`timescale 1ns/10ps
module gef_host #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   // Bus wire and handshake to the bench
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl = 1'b1,
   output logic      o_oe = 1'b0,
   output logic      o_done = 1'b0,
   output logic [7:0] o_rdata
);
   task automatic hp();
      repeat (5) @(negedge i_clk);
   endtask
   // SDA moves one cycle after SCL falls so no false START or STOP is seen
   task automatic bx(input logic b, output logic s);
      @(negedge i_clk);
      o_oe = !b;
      hp();
      o_scl = 1'b1;
      hp();
      s = i_sda;
      o_scl = 1'b0;
   endtask
   task automatic bt(input logic [7:0] d, output logic [7:0] r);
      for (int i = 7; i >= 0; i--)
         bx(d[i], r[i]);
   endtask
   task automatic edge_sda(input logic a, input logic b);
      @(negedge i_clk);
      o_oe = a;
      hp();
      o_scl = 1'b1;
      hp();
      o_oe = b;
      hp();
   endtask
   task automatic ptr(input logic [7:0] a);
      logic [7:0] r;
      logic       s;
      edge_sda(1'b0, 1'b1);
      o_scl = 1'b0;
      bt({ADDR, 1'b0}, r);
      bx(1'b1, s);
      bt(a, r);
      bx(1'b1, s);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic       s;
      ptr(a);
      bt(d, r);
      bx(1'b1, s);
      edge_sda(1'b1, 1'b0);
   endtask
   // Burst read from a; pointer wraps inside the FIFO window
   task automatic rd(input logic [7:0] a, input int n);
      logic [7:0] r;
      logic       s;
      ptr(a);
      edge_sda(1'b0, 1'b1);
      o_scl = 1'b0;
      bt({ADDR, 1'b1}, r);
      bx(1'b1, s);
      for (int k = 0; k < n; k++) begin
         bt(8'hff, r);
         bx(k == n - 1, s);
         o_rdata = r;
         o_done = 1'b1;
         @(negedge i_clk);
         o_done = 1'b0;
      end
      edge_sda(1'b1, 1'b0);
   endtask
endmodule

// File: gesture_engine_fifo_control_bench.sv
`timescale 1ns/10ps
`define CMP(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module gesture_engine_fifo_control_bench;
   logic sys_clk = 0, osc_clk = 0, rstn = 0, pv = 0, scl, hoe, oe, done, act, int_n;
   logic        sdo, led, led_seen = 0;
   logic [1:0]  drv, bst, gn;
   logic [7:0]  pr = 8'h00, th, rdata, exp_b, ex_u, ex_d, q[$];
   logic [31:0] pd;
   int          fail_count = 0, checks = 0, seed = 71529;
   // Open-drain wire: the device pulls to its data output only while enabled
   wire         sda = hoe ? 1'b0 : oe ? sdo : 1'b1;
   always #20 sys_clk = ~sys_clk;
   initial #3.3 forever #7.5 osc_clk = ~osc_clk;
   gef_host host_u (.i_clk(sys_clk), .i_sda(sda), .o_scl(scl), .o_oe(hoe), .o_done(done),
      .o_rdata(rdata));
   gef_engine #(.PULSE_UNIT_CYC(16'h0002), .WAIT_STEP_CYC(16'h0002)) dut_u (
      .i_sys_clk(sys_clk), .i_osc_clk(osc_clk), .i_rstn(rstn), .i_clk_en(1'b1),
      .i_scl(scl), .i_sda_in(sda), .o_sda_out(sdo), .o_sda_oe(oe), .i_prox_valid(pv),
      .i_prox_result(pr), .i_pd_sample(pd), .o_led_on(led), .o_led_drive(drv),
      .o_led_boost(bst), .o_amp_gain(gn), .o_engine_active(act), .o_int_n(int_n));
   always @(posedge sys_clk) if (done === 1'b1) begin
      exp_b = q.pop_front();
      `CMP("read data", exp_b, rdata)
   end
   always @(posedge led) led_seen <= 1'b1;
   task automatic rx(input logic [7:0] a, input logic [7:0] e);
      q.push_back(e);
      host_u.rd(a, 1);
   endtask
   task automatic prox(input logic [7:0] v);
      pr = v;
      pv = 1'b1;
      @(negedge sys_clk);
      pv = 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      pd = $random(seed);
      th = 8'h01 | 8'($random(seed));
      repeat (20) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (4) @(negedge sys_clk);
      rx(gef_pkg::ADDR_CONFIG_ONE_LOW_POWER, gef_pkg::RST_CONFIG_ONE_LOW_POWER);
      rx(gef_pkg::ADDR_CONFIG_TWO_LED_BOOST, gef_pkg::RST_CONFIG_TWO_LED_BOOST);
      rx(gef_pkg::ADDR_PULSE, gef_pkg::RST_PULSE);
      rx(8'h82, 8'h00);
      host_u.wr(gef_pkg::ADDR_ENTRY_TH, th);
      host_u.wr(gef_pkg::ADDR_PULSE, 8'h00);
      host_u.wr(gef_pkg::ADDR_GCONF4, 8'h02);
      host_u.wr(gef_pkg::ADDR_ENABLE, 8'h41);
      prox(th - 8'h01);
      `CMP("active low prox", 1'b0, act)
      prox(th);
      `CMP("active at entry", 1'b1, act)
      rx(gef_pkg::ADDR_GCONF4, 8'h03);
      for (int i = 0; i < 3000 && int_n !== 1'b0; i++) @(negedge sys_clk);
      `CMP("int pin", 1'b0, int_n)
      host_u.wr(gef_pkg::ADDR_GCONF4, 8'h02);
      `CMP("active after exit", 1'b0, act)
      rx(gef_pkg::ADDR_LEVEL, gef_pkg::FIFO_FULL_LVL);
      rx(gef_pkg::ADDR_GESTURE_STATUS_FLAGS, 8'h03);
      q.push_back(pd[7:0]);
      q.push_back(pd[15:8]);
      q.push_back(pd[23:16]);
      q.push_back(pd[31:24]);
      host_u.rd(gef_pkg::ADDR_FIFO_UP, 4);
      rx(gef_pkg::ADDR_LEVEL, 8'h1f);
      host_u.wr(gef_pkg::ADDR_GCONF4, 8'h06);
      rx(gef_pkg::ADDR_LEVEL, 8'h00);
      rx(gef_pkg::ADDR_GESTURE_STATUS_FLAGS, 8'h00);
      // False gesture: up/down floor at zero, left/right masked, exit on first dataset
      host_u.wr(gef_pkg::ADDR_EXIT_TH, 8'h01);
      host_u.wr(gef_pkg::ADDR_OFF_UP, 8'hff);
      host_u.wr(gef_pkg::ADDR_OFF_DOWN, 8'hff);
      host_u.wr(gef_pkg::ADDR_GCONF1, 8'hcd);
      prox(th);
      repeat (50) @(negedge sys_clk);
      `CMP("active after false", 1'b0, act)
      `CMP("int after false", 1'b1, int_n)
      rx(gef_pkg::ADDR_GCONF4, 8'h02);
      rx(gef_pkg::ADDR_LEVEL, 8'h00);
      rx(gef_pkg::ADDR_GESTURE_STATUS_FLAGS, 8'h00);
      // Up/down only, two pulses, 2x gain, wait states on: left/right read zero
      host_u.wr(gef_pkg::ADDR_GCONF1, 8'h00);
      host_u.wr(gef_pkg::ADDR_EXIT_TH, 8'h00);
      host_u.wr(gef_pkg::ADDR_OFF_UP, 8'h00);
      host_u.wr(gef_pkg::ADDR_OFF_DOWN, 8'h00);
      host_u.wr(gef_pkg::ADDR_GCONF3, 8'h01);
      host_u.wr(gef_pkg::ADDR_PULSE, 8'h01);
      host_u.wr(gef_pkg::ADDR_GCONF2, 8'h39);
      `CMP("gain", 2'h1, gn)
      `CMP("drive", 2'h3, drv)
      `CMP("boost", 2'h0, bst)
      prox(th);
      for (int i = 0; i < 3000 && int_n !== 1'b0; i++) @(negedge sys_clk);
      repeat (300) @(negedge sys_clk);
      host_u.wr(gef_pkg::ADDR_GCONF4, 8'h02);
      ex_u = (pd[7:6] != 2'h0) ? 8'hff : {pd[5:0], 2'h0};
      ex_d = (pd[15:14] != 2'h0) ? 8'hff : {pd[13:8], 2'h0};
      repeat (32) begin
         q.push_back(ex_u);
         q.push_back(ex_d);
         q.push_back(8'h00);
         q.push_back(8'h00);
      end
      host_u.rd(gef_pkg::ADDR_FIFO_UP, 128);
      `CMP("int after empty", 1'b1, int_n)
      `CMP("led pulsed", 1'b1, led_seen)
      rx(gef_pkg::ADDR_LEVEL, 8'h00);
      rx(gef_pkg::ADDR_GESTURE_STATUS_FLAGS, 8'h02);
      tally_and_finish();
   end
   initial begin
      #3_000_000;
      fail_count++;
      tally_and_finish();
   end
endmodule
